// ### design/lps_low_power_state_control.sv
// Low-power state controller: sequences Normal, halt, Stop-Grant, snoop, Sleep and Deep Sleep.
// Assumes chipset pins are asynchronous and core-side strobes share the controller clock.
`timescale 1ns/1ps
module lps_low_power_state_control #(
  parameter int unsigned LOCK_CYCLES = lps_pkg::LOCK_CYCLES,
  parameter int unsigned RESET_HOLD = lps_pkg::RESET_HOLD_CYCLES
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  // Chipset pins, asynchronous.
  input wire logic bus_clock,
  input wire logic stop_clock_request_n,
  input wire logic sleep_request_n,
  input wire logic system_mgmt_interrupt_n,
  input wire logic init_request_n,
  input wire logic [1:0] local_interrupt_lines,
  input wire logic bus_init_request_n,
  input wire logic flush_request_n,
  input wire logic reset_pin_n,
  input wire logic snoop_request,
  input wire logic snoop_serviced,
  // Core-side strobes, same clock.
  input wire logic halt_exec,
  input wire logic smm_return,
  input wire logic smm_resume_halt,
  input wire logic flush_done,
  input wire logic msr_write,
  input wire logic [11:0] msr_addr,
  input wire logic [31:0] msr_wdata,
  // State and clock controls.
  output lps_pkg::lps_state_t power_state,
  output logic core_clock_en,
  output logic l2_clock_en,
  output logic pll_run,
  output logic clock_stop_enable,
  // Services requested of the core.
  output logic core_init,
  output logic snoop_enable,
  output logic flush_service,
  output logic bus_init_service,
  output logic [3:0] irq_service
);
  import lps_pkg::*;

  logic [PIN_W-1:0] pins_sync;
  logic bus_running;
  lps_state_t state_r;
  lps_state_t state_nxt;
  logic stop_a, sleep_a, flush_a, rst_a, snoop_a, snoop_done;
  logic [3:0] irq_a, irq_prev_r, irq_ev, pend_r;
  logic bus_init_request_n_prev_r, rst_prev_r, bus_init_request_n_ev, rst_ev;
  logic resume_halt_r, return_halt_r;
  logic [LOCK_W-1:0] lock_cnt_r;
  logic [RESET_W-1:0] rst_cnt_r;
  logic rst_held, wake;

  // Core clocks stop in the clock-stopped states only while the control bit is set.
  function automatic logic core_on(input lps_state_t s, input logic stop_en);
    core_on = !(stop_en && (s == LPS_STOPGRANT || s == LPS_SLEEP || s == LPS_DEEPSLEEP ||
                            s == LPS_LOCKWAIT));
  endfunction

  // Pins pass two flops before any logic reads them.
  lps_pin_sync #(.W(PIN_W), .RESET_VAL(PIN_SYNC_RESET)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .enable(enable),
    .pins({bus_clock, stop_clock_request_n, sleep_request_n, system_mgmt_interrupt_n,
           init_request_n, local_interrupt_lines, bus_init_request_n, flush_request_n,
           reset_pin_n, snoop_request, snoop_serviced}),
    .pins_sync(pins_sync)
  );

  lps_bus_clock_monitor u_bus_mon (
    .clock(clock),
    .arst_n(arst_n),
    .enable(enable),
    .bus_clock_sync(pins_sync[PIN_BUS_CLOCK]),
    .running(bus_running)
  );

  // Active-level views of the synchronised pins.
  assign stop_a = !pins_sync[PIN_STOP];
  assign sleep_a = !pins_sync[PIN_SLEEP];
  assign flush_a = !pins_sync[PIN_FLUSH];
  assign rst_a = !pins_sync[PIN_RESET];
  assign snoop_a = pins_sync[PIN_SNOOP];
  assign snoop_done = pins_sync[PIN_SNOOP_DONE];
  assign irq_a = {!pins_sync[PIN_SMI], !pins_sync[PIN_INIT], pins_sync[PIN_LINT1],
                  pins_sync[PIN_LINT0]};
  assign irq_ev = irq_a & ~irq_prev_r;
  assign bus_init_request_n_ev = !pins_sync[PIN_BUS_INIT_REQUEST_N] && !bus_init_request_n_prev_r;
  assign rst_ev = rst_a && !rst_prev_r;
  assign rst_held = rst_a && (rst_cnt_r == RESET_W'(RESET_HOLD - 1));
  assign wake = |(irq_ev | pend_r);

  // Edge history of the event pins.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_prev_r <= 4'h0;
      bus_init_request_n_prev_r <= 1'b0;
      rst_prev_r <= 1'b0;
    end else if (enable) begin
      irq_prev_r <= irq_a;
      bus_init_request_n_prev_r <= !pins_sync[PIN_BUS_INIT_REQUEST_N];
      rst_prev_r <= rst_a;
    end
  end

  // Clock-stop control bit, written by the core.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      clock_stop_enable <= MSR_CLK_STOP_RESET;
    end else if (enable && msr_write && msr_addr == MSR_CLK_STOP_ADDR) begin
      clock_stop_enable <= msr_wdata[MSR_CLK_STOP_BIT];
    end
  end

  // Next power state.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      LPS_NORMAL: begin
        if (stop_a) state_nxt = LPS_STOPGRANT;
        else if (halt_exec) state_nxt = LPS_HALT;
        else if (smm_return && smm_resume_halt) state_nxt = LPS_HALT;
        else if (flush_a) state_nxt = LPS_FLUSH;
      end
      LPS_HALT: begin
        if (rst_ev) state_nxt = LPS_NORMAL;
        else if (stop_a) state_nxt = LPS_STOPGRANT;
        else if (snoop_a) state_nxt = LPS_SNOOP;
        else if (flush_a) state_nxt = LPS_FLUSH;
        else if (wake) state_nxt = LPS_NORMAL;
      end
      LPS_FLUSH: begin
        if (flush_done) state_nxt = return_halt_r ? LPS_HALT : LPS_NORMAL;
      end
      LPS_STOPGRANT: begin
        if (!stop_a) state_nxt = resume_halt_r ? LPS_HALT : LPS_NORMAL;
        else if (snoop_a) state_nxt = LPS_SNOOP;
        else if (sleep_a) state_nxt = LPS_SLEEP;
      end
      LPS_SNOOP: begin
        if (snoop_done) state_nxt = return_halt_r ? LPS_HALT : LPS_STOPGRANT;
      end
      LPS_SLEEP: begin
        if (rst_held) state_nxt = LPS_NORMAL;
        else if (!sleep_a && !rst_a) state_nxt = LPS_STOPGRANT;
        else if (!bus_running) state_nxt = LPS_DEEPSLEEP;
      end
      LPS_DEEPSLEEP: begin
        if (bus_running) state_nxt = LPS_LOCKWAIT;
      end
      LPS_LOCKWAIT: begin
        if (!bus_running) state_nxt = LPS_DEEPSLEEP;
        else if (lock_cnt_r == LOCK_W'(LOCK_CYCLES - 1)) state_nxt = LPS_SLEEP;
      end
      default: state_nxt = LPS_NORMAL;
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) state_r <= LPS_NORMAL;
    else if (enable) state_r <= state_nxt;
  end

  // Origin records for returns from Stop-Grant, snoop and flush.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      resume_halt_r <= 1'b0;
      return_halt_r <= 1'b0;
    end else if (enable) begin
      if (state_nxt == LPS_STOPGRANT && (state_r == LPS_NORMAL || state_r == LPS_HALT))
        resume_halt_r <= (state_r == LPS_HALT);
      if ((state_nxt == LPS_SNOOP || state_nxt == LPS_FLUSH) && state_nxt != state_r)
        return_halt_r <= (state_r == LPS_HALT);
    end
  end

  // Lock wait and reset hold counters.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lock_cnt_r <= '0;
      rst_cnt_r <= '0;
    end else if (enable) begin
      lock_cnt_r <= (state_r == LPS_LOCKWAIT) ? lock_cnt_r + LOCK_W'(1) : '0;
      if (!rst_a || state_r != LPS_SLEEP) rst_cnt_r <= '0;
      else if (!rst_held) rst_cnt_r <= rst_cnt_r + RESET_W'(1);
    end
  end

  // Pending interrupt events: latched in halt and Stop-Grant, serviced once in Normal.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pend_r <= 4'h0;
      irq_service <= 4'h0;
    end else if (enable) begin
      irq_service <= 4'h0;
      if (state_r == LPS_STOPGRANT || state_r == LPS_HALT) begin
        pend_r <= pend_r | irq_ev;
      end else if (state_r == LPS_NORMAL) begin
        irq_service <= irq_ev | pend_r;
        pend_r <= 4'h0;
      end
    end
  end

  // Core initialization and bus-init service pulses.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      core_init <= 1'b0;
      bus_init_service <= 1'b0;
    end else if (enable) begin
      core_init <= (rst_ev && (state_r == LPS_NORMAL || state_r == LPS_HALT ||
                   state_r == LPS_STOPGRANT)) || (state_r == LPS_SLEEP && rst_held);
      bus_init_service <= bus_init_request_n_ev && (state_r == LPS_NORMAL || state_r == LPS_HALT);
    end
  end

  // Registered clock and service controls, aligned with the state register.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_state <= LPS_NORMAL;
      core_clock_en <= 1'b1;
      l2_clock_en <= 1'b1;
      pll_run <= 1'b1;
      snoop_enable <= 1'b0;
      flush_service <= 1'b0;
    end else if (enable) begin
      power_state <= state_nxt;
      core_clock_en <= core_on(state_nxt, clock_stop_enable);
      l2_clock_en <= !(state_nxt == LPS_DEEPSLEEP || state_nxt == LPS_LOCKWAIT);
      pll_run <= (state_nxt != LPS_DEEPSLEEP);
      snoop_enable <= (state_nxt == LPS_SNOOP);
      flush_service <= (state_nxt == LPS_FLUSH);
    end
  end

  default clocking cb @(posedge clock iff enable);
  endclocking
  default disable iff (!arst_n);

  sequence s_snoop_in_sg;
    state_r == LPS_STOPGRANT && stop_a && snoop_a ##1 state_r == LPS_SNOOP;
  endsequence

  sequence s_sg_held;
    state_r == LPS_STOPGRANT ##1 state_r == LPS_STOPGRANT;
  endsequence

  a_halt_wake_normal: assert property (state_r == LPS_HALT && !rst_ev && !stop_a && !snoop_a &&
    !flush_a && wake |=> state_r == LPS_NORMAL) else $error("halt did not wake");
  a_halt_reset_init: assert property (state_r == LPS_HALT && rst_ev |=>
    core_init && state_r == LPS_NORMAL) else $error("halt reset missed");
  a_smm_resume_halt: assert property (state_r == LPS_NORMAL && !stop_a && smm_return &&
    smm_resume_halt |=> state_r == LPS_HALT) else $error("smm resume wrong");
  a_flush_back_halt: assert property (state_r == LPS_FLUSH && return_halt_r && flush_done |=>
    state_r == LPS_HALT && !flush_service) else $error("flush return wrong");
  a_sg_resume_halt: assert property (state_r == LPS_STOPGRANT && !stop_a && resume_halt_r |=>
    state_r == LPS_HALT) else $error("stop release lost halt");
  a_sg_entry: assert property (state_r == LPS_NORMAL && stop_a |=>
    state_r == LPS_STOPGRANT) else $error("stop not granted");
  a_sg_ignore_req: assert property (s_sg_held |-> !flush_service && !bus_init_service)
    else $error("request served in stop grant");
  a_sg_reset_stay: assert property (state_r == LPS_STOPGRANT && stop_a && rst_ev |=>
    core_init && state_r == LPS_STOPGRANT) else $error("reset left stop grant");
  a_snoop_return_sg: assert property (s_snoop_in_sg ##0 snoop_done |=>
    state_r == LPS_STOPGRANT) else $error("snoop return wrong");
  a_sleep_only_sg: assert property ($rose(state_r == LPS_SLEEP) |->
    $past(state_r) == LPS_STOPGRANT || $past(state_r) == LPS_LOCKWAIT)
    else $error("sleep from bad state");
  a_pend_service: assert property (state_r == LPS_NORMAL && pend_r[3] |=>
    irq_service[3] && !pend_r[3]) else $error("pending event lost");
  a_sleep_clocks: assert property (state_r == LPS_SLEEP && clock_stop_enable |->
    !core_clock_en && l2_clock_en && pll_run) else $error("sleep clocks wrong");
  a_sleep_no_latch: assert property (state_r == LPS_SLEEP |=> $stable(pend_r) || pend_r == 4'h0)
    else $error("latched in sleep");
  a_deep_entry: assert property (state_r == LPS_SLEEP && !bus_running && sleep_a && !rst_held
    |=> state_r == LPS_DEEPSLEEP && !l2_clock_en && !pll_run) else $error("deep missed");
  a_lock_exit_count: assert property (state_r == LPS_LOCKWAIT && state_nxt == LPS_SLEEP |->
    lock_cnt_r == LOCK_W'(LOCK_CYCLES - 1)) else $error("lock wait short");
  a_sleep_reset_skip: assert property (state_r == LPS_SLEEP && rst_held |=>
    state_r == LPS_NORMAL && core_init) else $error("sleep reset wrong");
  a_clk_stop_gate: assert property (state_r == LPS_STOPGRANT && !clock_stop_enable |->
    core_clock_en) else $error("clock stopped while gate clear");

endmodule

// ### design/lps_pkg.sv
// Shared constants and types for the low-power state controller.
// Assumes a single 125 MHz controller clock and pins that arrive asynchronously.
package lps_pkg;

  // Power states of the controller.
  typedef enum logic [3:0] {
    LPS_NORMAL    = 4'h0,
    LPS_HALT      = 4'h1,
    LPS_STOPGRANT = 4'h2,
    LPS_SNOOP     = 4'h3,
    LPS_SLEEP     = 4'h4,
    LPS_DEEPSLEEP = 4'h5,
    LPS_LOCKWAIT  = 4'h6,
    LPS_FLUSH     = 4'h7
  } lps_state_t;

  // Controller clock rate and the loop lock time after the bus clock restarts.
  localparam int unsigned CLOCK_MHZ = 125;
  localparam int unsigned LOCK_TIME_MS = 1;
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int unsigned LOCK_W = 17;

  // Cycles the reset pin must be held in Sleep before it resets the device.
  localparam int unsigned RESET_HOLD_CYCLES = 16;
  localparam int unsigned RESET_W = 8;

  // Cycles without a bus clock toggle before the bus clock counts as stopped.
  localparam logic [7:0] BUS_STOP_CYCLES = 8'h10;

  // Model-specific clock-stop control: register offset, bit position, reset value.
  localparam logic [11:0] MSR_CLK_STOP_ADDR = 12'h02a;
  localparam int unsigned MSR_CLK_STOP_BIT = 26;
  localparam logic MSR_CLK_STOP_RESET = 1'b1;

  // Pin synchroniser layout and idle levels.
  localparam int unsigned PIN_W = 12;
  localparam int unsigned PIN_BUS_CLOCK = 11;
  localparam int unsigned PIN_STOP = 10;
  localparam int unsigned PIN_SLEEP = 9;
  localparam int unsigned PIN_SMI = 8;
  localparam int unsigned PIN_INIT = 7;
  localparam int unsigned PIN_LINT1 = 6;
  localparam int unsigned PIN_LINT0 = 5;
  localparam int unsigned PIN_BUS_INIT_REQUEST_N = 4;
  localparam int unsigned PIN_FLUSH = 3;
  localparam int unsigned PIN_RESET = 2;
  localparam int unsigned PIN_SNOOP = 1;
  localparam int unsigned PIN_SNOOP_DONE = 0;
  localparam logic [PIN_W-1:0] PIN_SYNC_RESET = 12'h79c;

endpackage

// ### design/lps_pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins.
// Assumes each bit is an independent level; reset value is supplied per bit.
`timescale 1ns/1ps
module lps_pin_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  // Raw and synchronised levels.
  input wire logic [W-1:0] pins,
  output logic [W-1:0] pins_sync
);

  logic [W-1:0] meta_r;

  // First stage feeds only the second stage.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_r <= RESET_VAL;
      pins_sync <= RESET_VAL;
    end else if (enable) begin
      meta_r <= pins;
      pins_sync <= meta_r;
    end
  end

endmodule

// ### design/lps_bus_clock_monitor.sv
// Watches the synchronised bus clock and reports whether it is toggling.
// Assumes the input already passed a two-flop synchroniser.
`timescale 1ns/1ps
module lps_bus_clock_monitor (
  // Clock, reset and enable.
  input wire logic clock,
  input wire logic arst_n,
  input wire logic enable,
  // Synchronised bus clock and activity flag.
  input wire logic bus_clock_sync,
  output logic running
);
  import lps_pkg::*;

  logic prev_r;
  logic [7:0] idle_cnt_r;
  logic toggle;

  assign toggle = bus_clock_sync ^ prev_r;

  // Counts cycles since the last toggle; a long gap means the clock stopped.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_r <= 1'b0;
      idle_cnt_r <= 8'h00;
      running <= 1'b1;
    end else if (enable) begin
      prev_r <= bus_clock_sync;
      if (toggle) begin
        idle_cnt_r <= 8'h00;
        running <= 1'b1;
      end else if (idle_cnt_r == BUS_STOP_CYCLES - 8'h01) begin
        running <= 1'b0;
      end else begin
        idle_cnt_r <= idle_cnt_r + 8'h01;
      end
    end
  end

endmodule

// ### verification/lps_chipset_model.sv
// Chipset model: drives the sideband pins and the bus clock of the controller.
// Assumes the bench calls its tasks just after a rising edge of clock.
`timescale 1ns/1ps
module lps_chipset_model #(
  parameter int unsigned LOCK_WAIT = 50
) (
  // Controller clock.
  input wire logic clock,
  // Pins driven towards the controller.
  output logic bus_clock,
  output logic stop_clock_request_n,
  output logic sleep_request_n,
  output logic system_mgmt_interrupt_n,
  output logic init_request_n,
  output logic [1:0] local_interrupt_lines,
  output logic bus_init_request_n,
  output logic flush_request_n,
  output logic reset_pin_n,
  output logic snoop_request,
  output logic snoop_serviced
);
  logic bclk_run_r = 1'h1;

  // Bus clock of 30 ns period; it stands low while stopped, never left floating.
  always begin
    #15;
    bus_clock = bclk_run_r ? ~bus_clock : 1'h0;
  end

  // Every pin starts at its inactive level.
  initial begin
    bus_clock = 1'h0;
    stop_clock_request_n = 1'h1;
    sleep_request_n = 1'h1;
    system_mgmt_interrupt_n = 1'h1;
    init_request_n = 1'h1;
    local_interrupt_lines = 2'h0;
    bus_init_request_n = 1'h1;
    flush_request_n = 1'h1;
    reset_pin_n = 1'h1;
    snoop_request = 1'h0;
    snoop_serviced = 1'h0;
  end

  // Level pins change at once; only the Sleep reset scenario moves them (reset and stop-clock) while asleep.
  task automatic set_stop(input logic v);
    stop_clock_request_n = v;
  endtask
  task automatic set_flush(input logic v);
    flush_request_n = v;
  endtask
  task automatic set_reset(input logic v);
    reset_pin_n = v;
  endtask
  task automatic set_snoop(input logic req, input logic done);
    snoop_request = req;
    snoop_serviced = done;
  endtask

  // Sleep request is held for longer than one bus clock period after a change.
  task automatic set_sleep(input logic v);
    sleep_request_n = v;
    repeat (4) @(posedge clock);
    #1;
  endtask

  // One event: 0 mgmt, 1 init, 2 local 0, 3 local 1, other bus init.
  task automatic pulse(input int k);
    case (k)
      0: system_mgmt_interrupt_n = 1'h0;
      1: init_request_n = 1'h0;
      2: local_interrupt_lines[0] = 1'h1;
      3: local_interrupt_lines[1] = 1'h1;
      default: bus_init_request_n = 1'h0;
    endcase
    repeat (4) @(posedge clock);
    #1;
    system_mgmt_interrupt_n = 1'h1;
    init_request_n = 1'h1;
    local_interrupt_lines = 2'h0;
    bus_init_request_n = 1'h1;
    repeat (2) @(posedge clock);
    #1;
  endtask

  // Stopping the clock is only done while the device sleeps.
  task automatic stop_bclk();
    bclk_run_r = 1'h0;
  endtask

  // Restart, then give the loop its lock time before treating it as asleep.
  task automatic start_bclk();
    bclk_run_r = 1'h1;
    repeat (LOCK_WAIT + 20) @(posedge clock);
    #1;
  endtask
endmodule

// ### verification/lps_low_power_state_control_test.sv
// Bench for the low-power state controller: one task per scenario.
// Assumes the chipset model owns the pins and the bench the core-side strobes.
`timescale 1ns/1ps
module lps_low_power_state_control_test;
  import lps_pkg::*;
  localparam int unsigned LOCK_SIM = 50;
  localparam int unsigned HOLD_SIM = 4;
  // Clock, reset and core-side strobes.
  logic clock = 1'h0;
  logic arst_n = 1'h0;
  logic enable = 1'h1;
  logic halt_exec = 1'h0;
  logic smm_return = 1'h0;
  logic smm_resume_halt = 1'h0;
  logic flush_done = 1'h0;
  logic msr_write = 1'h0;
  logic [11:0] msr_addr = 12'h000;
  logic [31:0] msr_wdata = 32'h0000_0000;
  // Pins and outputs.
  wire logic bus_clock, stop_clock_request_n, sleep_request_n, system_mgmt_interrupt_n;
  wire logic init_request_n, bus_init_request_n, flush_request_n, reset_pin_n;
  wire logic snoop_request, snoop_serviced;
  wire logic [1:0] local_interrupt_lines;
  lps_state_t power_state;
  logic core_clock_en, l2_clock_en, pll_run, clock_stop_enable, core_init;
  logic snoop_enable, flush_service, bus_init_service;
  logic [3:0] irq_service;
  int error_cnt = 0;
  int n_compared = 0;
  int pulse_cnt [6];

  // Controller clock at 125 MHz.
  always #4 clock = ~clock;

  lps_low_power_state_control #(.LOCK_CYCLES(LOCK_SIM), .RESET_HOLD(HOLD_SIM)) uut (
    .clock(clock), .arst_n(arst_n), .enable(enable), .bus_clock(bus_clock),
    .stop_clock_request_n(stop_clock_request_n), .sleep_request_n(sleep_request_n),
    .system_mgmt_interrupt_n(system_mgmt_interrupt_n), .init_request_n(init_request_n),
    .local_interrupt_lines(local_interrupt_lines), .bus_init_request_n(bus_init_request_n),
    .flush_request_n(flush_request_n), .reset_pin_n(reset_pin_n),
    .snoop_request(snoop_request), .snoop_serviced(snoop_serviced), .halt_exec(halt_exec),
    .smm_return(smm_return), .smm_resume_halt(smm_resume_halt), .flush_done(flush_done),
    .msr_write(msr_write), .msr_addr(msr_addr), .msr_wdata(msr_wdata),
    .power_state(power_state), .core_clock_en(core_clock_en), .l2_clock_en(l2_clock_en),
    .pll_run(pll_run), .clock_stop_enable(clock_stop_enable), .core_init(core_init),
    .snoop_enable(snoop_enable), .flush_service(flush_service),
    .bus_init_service(bus_init_service), .irq_service(irq_service));

  lps_chipset_model #(.LOCK_WAIT(LOCK_SIM)) cs (
    .clock(clock), .bus_clock(bus_clock), .stop_clock_request_n(stop_clock_request_n),
    .sleep_request_n(sleep_request_n), .system_mgmt_interrupt_n(system_mgmt_interrupt_n),
    .init_request_n(init_request_n), .local_interrupt_lines(local_interrupt_lines),
    .bus_init_request_n(bus_init_request_n), .flush_request_n(flush_request_n),
    .reset_pin_n(reset_pin_n), .snoop_request(snoop_request),
    .snoop_serviced(snoop_serviced));

  // Shared helpers: stepping, comparing, waiting for a state, counting pulses.
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s is %0h, expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_state(input lps_state_t s, input int limit);
    int i;
    for (i = 0; i < limit && power_state !== s; i++) step(1);
    check(power_state, s, "power_state");
  endtask
  task automatic watch(input int n);
    pulse_cnt = '{default: 0};
    repeat (n) begin
      step(1);
      for (int k = 0; k < 4; k++) pulse_cnt[k] += int'(irq_service[k] === 1'h1);
      pulse_cnt[4] += int'(core_init === 1'h1);
      pulse_cnt[5] += int'(bus_init_service === 1'h1);
    end
  endtask
  task automatic do_halt();
    halt_exec = 1'h1;
    step(1);
    halt_exec = 1'h0;
  endtask
  task automatic msr_wr(input logic [11:0] a, input logic [31:0] d);
    msr_write = 1'h1;
    msr_addr = a;
    msr_wdata = d;
    step(1);
    msr_write = 1'h0;
  endtask

  // Reset values of state and clock controls.
  task automatic t_reset();
    check(power_state, LPS_NORMAL, "state");
    check({core_clock_en, l2_clock_en, pll_run}, 3'h7, "clock enables");
    check(clock_stop_enable, MSR_CLK_STOP_RESET, "stop bit");
  endtask

  // Halt, then each wake source returns to Normal and is serviced once.
  task automatic t_halt_wake();
    int bit_of [4] = '{3, 2, 0, 1};
    for (int k = 0; k < 4; k++) begin
      do_halt();
      check(power_state, LPS_HALT, "halt");
      fork cs.pulse(k); watch(20); join
      check(power_state, LPS_NORMAL, "woken");
      check(pulse_cnt[bit_of[k]], 1, "wake service");
    end
  endtask

  // Handler return chooses halt or Normal.
  task automatic t_smm();
    for (int k = 1; k >= 0; k--) begin
      smm_return = 1'h1;
      smm_resume_halt = k[0];
      step(1);
      smm_return = 1'h0;
      check(power_state, k ? LPS_HALT : LPS_NORMAL, "handler return");
      if (k == 1) fork cs.pulse(3); watch(20); join
    end
  endtask

  // Flush served from halt, then the reset pin initializes at once.
  task automatic t_halt_flush_reset();
    do_halt();
    cs.set_flush(1'h0);
    wait_state(LPS_FLUSH, 6);
    check(flush_service, 1'h1, "flush service");
    cs.set_flush(1'h1);
    step(3);
    flush_done = 1'h1;
    step(1);
    flush_done = 1'h0;
    check(power_state, LPS_HALT, "after flush");
    cs.set_reset(1'h0);
    watch(8);
    cs.set_reset(1'h1);
    check(pulse_cnt[4], 1, "init in halt");
    check(power_state, LPS_NORMAL, "state after reset");
  endtask

  // In halt: sleep ignored, snoop taken and returned, stop-clock resumes halt.
  task automatic t_halt_stop();
    do_halt();
    cs.set_sleep(1'h0);
    check(power_state, LPS_HALT, "sleep in halt");
    cs.set_sleep(1'h1);
    cs.set_snoop(1'h1, 1'h0);
    wait_state(LPS_SNOOP, 6);
    check(snoop_enable, 1'h1, "snoop enable");
    cs.set_snoop(1'h0, 1'h1);
    wait_state(LPS_HALT, 6);
    cs.set_snoop(1'h0, 1'h0);
    cs.set_stop(1'h0);
    wait_state(LPS_STOPGRANT, 6);
    cs.set_stop(1'h1);
    wait_state(LPS_HALT, 6);
    fork cs.pulse(0); watch(20); join
  endtask

  // Stop-Grant ignores flush and bus init, latches events, survives reset.
  task automatic t_stopgrant();
    cs.set_stop(1'h0);
    wait_state(LPS_STOPGRANT, 6);
    check(core_clock_en, 1'h0, "core clock");
    cs.set_flush(1'h0);
    fork cs.pulse(4); watch(10); join
    check(power_state, LPS_STOPGRANT, "flush ignored");
    check(pulse_cnt[5], 0, "bus init ignored");
    cs.set_flush(1'h1);
    cs.set_reset(1'h0);
    watch(8);
    cs.set_reset(1'h1);
    check(pulse_cnt[4], 1, "init in stop-grant");
    check(power_state, LPS_STOPGRANT, "stays");
    cs.set_snoop(1'h1, 1'h1);
    wait_state(LPS_SNOOP, 6);
    cs.set_snoop(1'h0, 1'h1);
    wait_state(LPS_STOPGRANT, 6);
    cs.set_snoop(1'h0, 1'h0);
    cs.pulse(0);
    cs.pulse(0);
    cs.pulse(2);
    cs.set_stop(1'h1);
    watch(20);
    check(power_state, LPS_NORMAL, "released");
    check(pulse_cnt[3] * 16 + pulse_cnt[0], 8'h11, "latched once");
    check(pulse_cnt[2], 0, "no init event");
  endtask

  // Sleep, Deep Sleep, loop relock and the way back.
  task automatic t_sleep();
    cs.set_sleep(1'h0);
    check(power_state, LPS_NORMAL, "sleep in normal");
    cs.set_sleep(1'h1);
    cs.set_stop(1'h0);
    wait_state(LPS_STOPGRANT, 6);
    cs.set_sleep(1'h0);
    wait_state(LPS_SLEEP, 6);
    check({core_clock_en, pll_run, l2_clock_en}, 3'h3, "sleep clocks");
    cs.stop_bclk();
    wait_state(LPS_DEEPSLEEP, 40);
    check({pll_run, l2_clock_en}, 2'h0, "deep clocks");
    fork cs.start_bclk(); step(LOCK_SIM / 2); join_any
    check(l2_clock_en, 1'h0, "l2 during lock");
    wait fork;
    check(power_state, LPS_SLEEP, "relocked");
    check(l2_clock_en, 1'h1, "l2 back");
    cs.set_sleep(1'h1);
    wait_state(LPS_STOPGRANT, 6);
    cs.set_stop(1'h1);
    wait_state(LPS_NORMAL, 6);
  endtask

  // Reset held in Sleep initializes without passing Stop-Grant.
  task automatic t_sleep_reset();
    cs.set_stop(1'h0);
    wait_state(LPS_STOPGRANT, 6);
    cs.set_sleep(1'h0);
    wait_state(LPS_SLEEP, 6);
    cs.set_reset(1'h0);
    cs.set_stop(1'h1);
    fork cs.set_sleep(1'h1); watch(HOLD_SIM + 4); join
    check(pulse_cnt[4], 1, "init from sleep");
    check(power_state, LPS_NORMAL, "sleep reset state");
    cs.set_reset(1'h1);
    wait_state(LPS_NORMAL, 20);
  endtask

  // Clock enable low freezes every flop, the pin synchronisers too.
  task automatic t_enable();
    enable = 1'h0;
    cs.set_stop(1'h0);
    step(6);
    check(power_state, LPS_NORMAL, "frozen");
    enable = 1'h1;
    wait_state(LPS_STOPGRANT, 6);
    cs.set_stop(1'h1);
    wait_state(LPS_NORMAL, 6);
  endtask

  // Clock-stop bit: other addresses leave it, clearing it keeps the core clock.
  task automatic t_msr();
    msr_wr(MSR_CLK_STOP_ADDR + 12'h001, 32'h0000_0000);
    check(clock_stop_enable, 1'h1, "other address");
    msr_wr(MSR_CLK_STOP_ADDR, 32'hfbff_ffff);
    check(clock_stop_enable, 1'h0, "bit cleared");
    cs.set_stop(1'h0);
    wait_state(LPS_STOPGRANT, 6);
    check(core_clock_en, 1'h1, "core clock kept");
    cs.set_stop(1'h1);
    wait_state(LPS_NORMAL, 6);
    msr_wr(MSR_CLK_STOP_ADDR, 32'h0400_0000);
    check(clock_stop_enable, 1'h1, "bit set");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence after eight cycles of reset.
  initial begin
    repeat (8) @(posedge clock);
    #1;
    arst_n = 1'h1;
    step(2);
    t_reset();
    t_halt_wake();
    t_smm();
    t_halt_flush_reset();
    t_halt_stop();
    t_stopgrant();
    t_sleep();
    t_sleep_reset();
    t_msr();
    t_enable();
    finish_test();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #100_000;
    error_cnt++;
    finish_test();
  end
endmodule
